//--- design/dacud_pkg.sv
package dacud_pkg;

  // register indices on the plain register port
  localparam logic [4:0] A_NOP = 5'h00;
  localparam logic [4:0] A_INPUT = 5'h01;
  localparam logic [4:0] A_OUTPUT = 5'h02;
  localparam logic [4:0] A_FALLBACK = 5'h03;
  localparam logic [4:0] A_GAIN = 5'h04;
  localparam logic [4:0] A_OFFSET = 5'h05;
  localparam logic [4:0] A_DAC_CFG = 5'h06;
  localparam logic [4:0] A_SOFT_LOAD = 5'h07;
  localparam logic [4:0] A_KEY = 5'h08;
  localparam logic [4:0] A_PIN_FUNC = 5'h09;
  localparam logic [4:0] A_PIN_DATA = 5'h0A;
  localparam logic [4:0] A_GEN_CFG1 = 5'h0B;
  localparam logic [4:0] A_GEN_CFG2 = 5'h0C;
  localparam logic [4:0] A_CHECK_CFG = 5'h0D;
  localparam logic [4:0] A_DIG_FLAGS = 5'h0E;
  localparam logic [4:0] A_ANA_FLAGS = 5'h0F;
  localparam logic [4:0] A_STATUS = 5'h10;
  localparam logic [4:0] A_TICKS = 5'h11;
  localparam logic [4:0] A_RB_PTR = 5'h12;
  localparam logic [4:0] A_WDT_CFG = 5'h13;

  // field positions
  localparam int unsigned B_SLEW_EN = 4;
  localparam int unsigned B_FB_ON_TO = 10;
  localparam int unsigned B_RST_ON_TO = 9;
  localparam int unsigned B_INV_EN = 0;
  localparam int unsigned B_MON_EN = 1;
  localparam int unsigned B_SUM_EN = 2;
  localparam int unsigned B_TICK_EN = 3;
  localparam int unsigned B_CLK_STOP_EN = 0;
  localparam int unsigned B_GLOBAL_LOAD = 0;

  // digital fault flag bits
  localparam int unsigned F_RESET = 0;
  localparam int unsigned F_UNREF = 1;
  localparam int unsigned F_WDT = 2;
  localparam int unsigned F_LATCH = 3;
  localparam int unsigned F_INVERSE = 4;
  localparam int unsigned F_SUM = 5;
  localparam int unsigned F_INVALID = 6;
  localparam int unsigned F_SLEW = 7;

  // reset values
  localparam logic [15:0] GAIN_RST = 16'hFFFF;
  localparam logic [15:0] OFFSET_RST = 16'h8000;
  localparam logic [15:0] MID_SCALE = 16'h8000;
  localparam logic [7:0] DFLAGS_RST = 8'h03;

  // key codes; refresh, conversion and kick values are arbitrary
  localparam logic [15:0] KEY_RST1 = 16'h15FA;
  localparam logic [15:0] KEY_RST2 = 16'hAF51;
  localparam logic [15:0] KEY_REFRESH = 16'h1111;
  localparam logic [15:0] KEY_ADC = 16'h2222;
  localparam logic [15:0] KEY_KICK = 16'h3333;

  // general purpose pin modes
  localparam logic [1:0] PIN_PULLDOWN = 2'h0;
  localparam logic [1:0] PIN_OUTPUT = 2'h1;
  localparam logic [1:0] PIN_INPUT = 2'h2;

  // timing and sizes
  localparam int unsigned TICK_DIV = 10000;
  localparam logic [4:0] TRIM_WORDS = 5'h10;
  localparam logic [23:0] DEAD_CODE = 24'h07DEAD;

  typedef enum logic [0:0] {RF_IDLE, RF_READ} dacud_rf_t;

endpackage : dacud_pkg

//--- design/dacud_pin_cell.sv
`timescale 1ns/100ps
`default_nettype none
module dacud_pin_cell
  import dacud_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [1:0] mode,
  input wire logic out_val,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic pin_pulldown,
  output logic rd_val
);

  typedef struct packed {
    logic meta;
    logic sync;
  } dacud_pin_st_t;

  dacud_pin_st_t s_q;
  dacud_pin_st_t s_d;

  // two-stage capture, the pin is asynchronous to clk_sys
  always_comb begin
    s_d = s_q;
    s_d.meta = pin_in;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // unknown mode codes fall back to the safe pulldown
  assign pin_oe = (mode == PIN_OUTPUT);
  assign pin_out = out_val & (mode == PIN_OUTPUT);
  assign pin_pulldown = (mode != PIN_OUTPUT) && (mode != PIN_INPUT);
  assign rd_val = (mode == PIN_INPUT) ? s_q.sync :
                  (mode == PIN_OUTPUT) ? out_val : 1'b0;

endmodule : dacud_pin_cell
`default_nettype wire

//--- design/dacud_tick.sv
`timescale 1ns/100ps
`default_nettype none
module dacud_tick #(
  parameter int unsigned DIV = 10000
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic enable,
  output logic tick,
  output logic [15:0] count
);

  typedef struct packed {
    logic [13:0] div;
    logic [15:0] cnt;
    logic tick;
  } dacud_tick_st_t;

  localparam logic [13:0] DIV_LAST = 14'(DIV - 1);

  dacud_tick_st_t s_q;
  dacud_tick_st_t s_d;

  // counter wraps on its own width and keeps running
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (!enable) begin
      s_d.div = '0;
    end else if (s_q.div == DIV_LAST) begin
      s_d.div = '0;
      s_d.tick = 1'b1;
      s_d.cnt = s_q.cnt + 16'h0001;
    end else begin
      s_d.div = s_q.div + 14'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
  assign count = s_q.cnt;

endmodule : dacud_tick
`default_nettype wire

//--- design/dacud_core.sv
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - input write with load strobe low loads output at frame select rise
// - strobe high: hold until soft load command or strobe pulsed low
// - watchdog timeout with fallback bit copies fallback code to output
// - with slew on, output code steps toward target
// - global load bit makes soft load ignore device address bits
// - keep code and inverse; check match before strobing converter
// - latch monitor compares converter latch readback with internal code
// - three pins: output, input or pulldown default; data reg reads/drives
// - key values start refresh, soft reset, conversion or watchdog kick
// - soft reset needs key 0x15FA then 0xAF51 back to back
// - any reset sets reset seen flag; reads one after power-up
// - refresh by key or span change checks sum against reference
// - during refresh only pointer or no-op writes; others flag error
// - tick counter increments every 10000 clocks when enabled
// - stopped clock reporting sends fixed dead code, enable bit controls
// - fault flags sticky; writing one reloads current fault state
// - unrefreshed and slew busy flags clear themselves, not by writes
// - status holds analog OR and digital OR excluding slew busy
// - gain or offset writes alone never change the output
// - after timeout ignore input writes and loads until fault cleared
module dacud_core
  import dacud_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_DIV
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic frame_select_n,
  input wire logic load_strobe_pin_n,
  input wire logic [1:0] dev_addr,
  input wire logic wdt_timeout,
  input wire logic [15:0] latch_readback,
  input wire logic [7:0] analog_faults,
  input wire logic [15:0] trim_data,
  input wire logic [15:0] trim_ref,
  input wire logic [2:0] pin_in,
  output logic [2:0] pin_out,
  output logic [2:0] pin_oe,
  output logic [2:0] pin_pulldown,
  output logic [15:0] dac_latch_code,
  output logic [3:0] trim_addr,
  output logic refresh_busy,
  output logic adc_start,
  output logic wdt_kick,
  output logic dead_code_enable,
  output logic [23:0] dead_code
);

  typedef struct packed {
    logic [15:0] rdata;
    logic [15:0] pend;
    logic [15:0] target;
    logic [15:0] code;
    logic [15:0] code_inv;
    logic [15:0] latch;
    logic [15:0] fallback;
    logic [15:0] gain;
    logic [15:0] offset;
    logic [15:0] user_in;
    logic [3:0] span;
    logic slew_en;
    logic [3:0] slew_step;
    logic [5:0] pin_cfg;
    logic [2:0] pin_val;
    logic clk_stop_en;
    logic global_load;
    logic inv_en;
    logic mon_en;
    logic sum_en;
    logic tick_en;
    logic fb_on_to;
    logic rst_on_to;
    logic [7:0] dflags;
    logic [7:0] aflags;
    logic [4:0] rb_ptr;
    logic armed;
    logic key1;
    logic adc_go;
    logic kick;
    logic fs_m;
    logic fs_s;
    logic fs_p;
    logic ld_m;
    logic ld_s;
    logic ld_p;
    logic [15:0] mon_m;
    logic [15:0] mon_s;
    logic [1:0] dev_m;
    logic [1:0] dev_s;
    logic [1:0] settle;
    dacud_rf_t rf;
    logic [4:0] cnt;
    logic [15:0] sum;
  } dacud_st_t;

  // one reset image serves the pin reset and the soft reset
  function automatic dacud_st_t rst_val();
    dacud_st_t r;
    r = '0;
    r.gain = GAIN_RST;
    r.offset = OFFSET_RST;
    r.code_inv = 16'hFFFF;
    r.inv_en = 1'b1;
    r.sum_en = 1'b1;
    r.tick_en = 1'b1;
    r.clk_stop_en = 1'b1;
    r.dflags = DFLAGS_RST;
    r.fs_m = 1'b1;
    r.fs_s = 1'b1;
    r.fs_p = 1'b1;
    r.ld_m = 1'b1;
    r.ld_s = 1'b1;
    r.ld_p = 1'b1;
    r.rf = RF_IDLE;
    return r;
  endfunction : rst_val

  localparam dacud_st_t ST_RST = rst_val();

  dacud_st_t s_q;
  dacud_st_t s_d;
  logic tick;
  logic [15:0] tick_count;
  logic [2:0] pin_rd;

  // general purpose pin slices
  for (genvar g = 0; g < 3; g++) begin : g_pin
    dacud_pin_cell u_pin (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .mode(s_q.pin_cfg[2*g +: 2]),
      .out_val(s_q.pin_val[g]),
      .pin_in(pin_in[g]),
      .pin_out(pin_out[g]),
      .pin_oe(pin_oe[g]),
      .pin_pulldown(pin_pulldown[g]),
      .rd_val(pin_rd[g])
    );
  end

  dacud_tick #(
    .DIV(TICK_CYCLES)
  ) u_tick (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .enable(s_q.tick_en),
    .tick(tick),
    .count(tick_count)
  );

  // calibration: D*(M+1)/2^16 + C - 2^15, clamped to the code range
  logic [32:0] cal_prod;
  logic [18:0] cal_sum;
  logic [15:0] cal_code;
  always_comb begin
    cal_prod = reg_wdata * ({1'b0, s_q.gain} + 17'h00001);
    cal_sum = {2'b00, cal_prod[32:16]} + {3'b000, s_q.offset}
              - {3'b000, MID_SCALE};
    if (cal_sum[18]) begin
      cal_code = 16'h0000;
    end else if (cal_sum[17:16] != 2'b00) begin
      cal_code = 16'hFFFF;
    end else begin
      cal_code = cal_sum[15:0];
    end
  end

  logic [15:0] step;
  logic [15:0] sum_final;
  always_comb begin
    step = {12'h000, s_q.slew_step} + 16'h0001;
    sum_final = s_q.sum + trim_data;
  end

  // main next-state process
  always_comb begin
    logic frame_end;
    logic ld_fall;
    logic blocked;
    logic wr_ok;
    logic wdt_hold;
    logic soft_ld;
    logic soft_rst;
    logic start_rf;
    logic load;
    logic mon_bad;
    logic inv_bad;
    logic [7:0] set;
    logic [7:0] live;
    frame_end = 1'b0;
    ld_fall = 1'b0;
    blocked = 1'b0;
    wr_ok = 1'b0;
    wdt_hold = 1'b0;
    soft_ld = 1'b0;
    soft_rst = 1'b0;
    start_rf = 1'b0;
    load = 1'b0;
    mon_bad = 1'b0;
    inv_bad = 1'b0;
    set = '0;
    live = '0;
    s_d = s_q;
    // synchronisers for the pins
    s_d.fs_m = frame_select_n;
    s_d.fs_s = s_q.fs_m;
    s_d.fs_p = s_q.fs_s;
    s_d.ld_m = load_strobe_pin_n;
    s_d.ld_s = s_q.ld_m;
    s_d.ld_p = s_q.ld_s;
    s_d.mon_m = latch_readback;
    s_d.mon_s = s_q.mon_m;
    s_d.dev_m = dev_addr;
    s_d.dev_s = s_q.dev_m;
    s_d.adc_go = 1'b0;
    s_d.kick = 1'b0;
    frame_end = s_q.fs_s & ~s_q.fs_p;
    ld_fall = s_q.ld_p & ~s_q.ld_s;
    wdt_hold = s_q.dflags[F_WDT];
    blocked = (s_q.rf == RF_READ) && (reg_addr != A_RB_PTR)
              && (reg_addr != A_NOP);
    wr_ok = reg_wr & ~blocked;
    if (reg_wr && blocked) begin
      set[F_INVALID] = 1'b1;
    end
    // register writes
    if (wr_ok) begin
      unique case (reg_addr)
        A_INPUT: begin
          if (!wdt_hold) begin
            s_d.user_in = reg_wdata;
            s_d.pend = cal_code;
            s_d.armed = 1'b1;
          end
        end
        A_FALLBACK: s_d.fallback = reg_wdata;
        A_GAIN: s_d.gain = reg_wdata;
        A_OFFSET: s_d.offset = reg_wdata;
        A_DAC_CFG: begin
          start_rf = (reg_wdata[3:0] != s_q.span);
          s_d.span = reg_wdata[3:0];
          s_d.slew_en = reg_wdata[B_SLEW_EN];
          s_d.slew_step = reg_wdata[11:8];
        end
        A_SOFT_LOAD: begin
          soft_ld = s_q.global_load || (reg_wdata[1:0] == s_q.dev_s);
        end
        A_KEY: begin
          soft_rst = s_q.key1 && (reg_wdata == KEY_RST2);
          s_d.key1 = (reg_wdata == KEY_RST1);
          start_rf = (reg_wdata == KEY_REFRESH);
          s_d.adc_go = (reg_wdata == KEY_ADC);
          s_d.kick = (reg_wdata == KEY_KICK);
        end
        A_PIN_FUNC: s_d.pin_cfg = reg_wdata[5:0];
        A_PIN_DATA: s_d.pin_val = reg_wdata[2:0];
        A_GEN_CFG1: s_d.clk_stop_en = reg_wdata[B_CLK_STOP_EN];
        A_GEN_CFG2: s_d.global_load = reg_wdata[B_GLOBAL_LOAD];
        A_CHECK_CFG: begin
          s_d.inv_en = reg_wdata[B_INV_EN];
          s_d.mon_en = reg_wdata[B_MON_EN];
          s_d.sum_en = reg_wdata[B_SUM_EN];
          s_d.tick_en = reg_wdata[B_TICK_EN];
        end
        A_RB_PTR: s_d.rb_ptr = reg_wdata[4:0];
        A_WDT_CFG: begin
          s_d.fb_on_to = reg_wdata[B_FB_ON_TO];
          s_d.rst_on_to = reg_wdata[B_RST_ON_TO];
        end
        default: ;
      endcase
    end
    // load events; the strobe low at frame end loads at once
    load = soft_ld
           | (frame_end & s_q.armed & ~s_q.ld_s)
           | ld_fall;
    if (frame_end) begin
      s_d.armed = 1'b0;
    end
    if (load && !wdt_hold) begin
      s_d.target = s_q.pend;
    end
    // watchdog timeout
    if (wdt_timeout) begin
      set[F_WDT] = 1'b1;
      if (s_q.fb_on_to) begin
        s_d.target = s_q.fallback;
      end
    end
    // output code: direct, or ramped on each tick
    if (!s_q.slew_en || (wdt_timeout && s_q.fb_on_to)) begin
      s_d.code = s_d.target;
    end else if (tick) begin
      if (s_q.target > s_q.code) begin
        s_d.code = (s_q.target - s_q.code > step) ?
                   s_q.code + step : s_q.target;
      end else begin
        s_d.code = (s_q.code - s_q.target > step) ?
                   s_q.code - step : s_q.target;
      end
    end
    s_d.code_inv = ~s_d.code;
    // converter strobed only with a consistent code pair
    inv_bad = s_q.inv_en && (s_q.code != ~s_q.code_inv);
    if (inv_bad) begin
      set[F_INVERSE] = 1'b1;
    end else begin
      s_d.latch = s_q.code;
    end
    // readback lags by the sync stages, so wait for it to settle
    if (s_d.latch != s_q.latch) begin
      s_d.settle = 2'b00;
    end else if (s_q.settle != 2'b11) begin
      s_d.settle = s_q.settle + 2'b01;
    end
    mon_bad = s_q.mon_en && (s_q.settle == 2'b11)
              && (s_q.mon_s != s_q.latch);
    set[F_LATCH] = mon_bad;
    // trim memory refresh walk
    unique case (s_q.rf)
      RF_IDLE: begin
        if (start_rf) begin
          s_d.rf = RF_READ;
          s_d.cnt = '0;
          s_d.sum = '0;
        end
      end
      RF_READ: begin
        s_d.cnt = s_q.cnt + 5'h01;
        if (s_q.cnt != 5'h00) begin
          s_d.sum = sum_final;
        end
        if (s_q.cnt == TRIM_WORDS) begin
          s_d.rf = RF_IDLE;
          set[F_SUM] = s_q.sum_en && (sum_final != trim_ref);
        end
      end
    endcase
    // sticky flags: set wins, a write of one reloads the live state
    live[F_LATCH] = mon_bad;
    live[F_INVERSE] = inv_bad;
    for (int i = 0; i < 8; i++) begin
      if (wr_ok && reg_addr == A_DIG_FLAGS && reg_wdata[i]) begin
        s_d.dflags[i] = live[i] | set[i];
      end else begin
        s_d.dflags[i] = s_q.dflags[i] | set[i];
      end
      if (wr_ok && reg_addr == A_ANA_FLAGS && reg_wdata[i]) begin
        s_d.aflags[i] = analog_faults[i];
      end else begin
        s_d.aflags[i] = s_q.aflags[i] | analog_faults[i];
      end
    end
    // self-clearing flags, not touched by writes
    if (s_q.rf == RF_READ && s_q.cnt == TRIM_WORDS) begin
      s_d.dflags[F_UNREF] = 1'b0;
    end else begin
      s_d.dflags[F_UNREF] = s_q.dflags[F_UNREF];
    end
    s_d.dflags[F_SLEW] = (s_d.code != s_d.target);
    // read data stand for one cycle only
    s_d.rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        A_INPUT: s_d.rdata = s_q.user_in;
        A_OUTPUT: s_d.rdata = s_q.code;
        A_FALLBACK: s_d.rdata = s_q.fallback;
        A_GAIN: s_d.rdata = s_q.gain;
        A_OFFSET: s_d.rdata = s_q.offset;
        A_DAC_CFG: s_d.rdata = {4'h0, s_q.slew_step, 3'b000,
                                s_q.slew_en, s_q.span};
        A_PIN_FUNC: s_d.rdata = {10'h000, s_q.pin_cfg};
        A_PIN_DATA: s_d.rdata = {13'h0000, pin_rd};
        A_GEN_CFG1: s_d.rdata = {15'h0000, s_q.clk_stop_en};
        A_GEN_CFG2: s_d.rdata = {15'h0000, s_q.global_load};
        A_CHECK_CFG: s_d.rdata = {12'h000, s_q.tick_en, s_q.sum_en,
                                  s_q.mon_en, s_q.inv_en};
        A_DIG_FLAGS: s_d.rdata = {8'h00, s_q.dflags};
        A_ANA_FLAGS: s_d.rdata = {8'h00, s_q.aflags};
        A_STATUS: s_d.rdata = {13'h0000, s_q.dflags[F_WDT],
                               |(s_q.dflags & ~(8'h01 << F_SLEW)),
                               |s_q.aflags};
        A_TICKS: s_d.rdata = tick_count;
        A_RB_PTR: s_d.rdata = {11'h000, s_q.rb_ptr};
        A_WDT_CFG: s_d.rdata = {5'h00, s_q.fb_on_to, s_q.rst_on_to,
                                9'h000};
        default: s_d.rdata = '0;
      endcase
    end
    // soft reset by key pair or configured timeout; flag survives
    if (soft_rst || (wdt_timeout && s_q.rst_on_to)) begin
      s_d = ST_RST;
      s_d.dflags[F_RESET] = 1'b1;
      s_d.dflags[F_WDT] = wdt_timeout;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign reg_rdata = s_q.rdata;
  assign dac_latch_code = s_q.latch;
  assign trim_addr = s_q.cnt[3:0];
  assign refresh_busy = (s_q.rf == RF_READ);
  assign adc_start = s_q.adc_go;
  assign wdt_kick = s_q.kick;
  // the stopped clock cannot report itself; the serial shifter uses this
  assign dead_code_enable = s_q.clk_stop_en;
  assign dead_code = DEAD_CODE;

endmodule : dacud_core
`default_nettype wire

//--- tb/dacud_far_model.sv
`timescale 1ns/100ps
`default_nettype none
module dacud_far_model (
  input wire logic clk_sys,
  input wire logic [15:0] dac_latch_code,
  input wire logic [3:0] trim_addr,
  input wire logic corrupt,
  input wire logic bad_ref,
  output logic [15:0] latch_readback,
  output logic [15:0] trim_data,
  output logic [15:0] trim_ref
);
  // latches echo the code; corrupt flips bit 0 to mimic an upset
  assign latch_readback = dac_latch_code ^ {15'h0000, corrupt};
  // trim array answers one cycle after the address, like the real memory
  always_ff @(posedge clk_sys) begin
    trim_data <= {4'hA, 8'h00, trim_addr};
  end
  // sum of all sixteen words is 0x0078; bad_ref fakes a stale reference
  assign trim_ref = bad_ref ? 16'h0077 : 16'h0078;
endmodule : dacud_far_model
`default_nettype wire

//--- tb/dacud_core_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module dacud_core_asserts
  import dacud_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_DIV
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [2:0] pin_oe,
  input wire logic [2:0] pin_pulldown,
  input wire logic [3:0] trim_addr,
  input wire logic refresh_busy,
  input wire logic adc_start,
  input wire logic wdt_kick,
  input wire logic [23:0] dead_code
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // key writes count only while no refresh blocks them
  sequence s_key(logic [15:0] k);
    reg_wr && reg_addr == A_KEY && reg_wdata == k && !refresh_busy;
  endsequence
  sequence s_walk;
    refresh_busy[*8] ##1 refresh_busy[*8] ##1 refresh_busy ##1 !refresh_busy;
  endsequence
  property p_adc;
    s_key(KEY_ADC) |=> adc_start ##1 !adc_start;
  endproperty
  a_adc: assert property (p_adc)
    else $error("conversion pulse wrong after key");
  property p_kick;
    s_key(KEY_KICK) |=> wdt_kick ##1 !wdt_kick;
  endproperty
  a_kick: assert property (p_kick)
    else $error("kick pulse wrong after key");
  property p_ref_start;
    s_key(KEY_REFRESH) |=> refresh_busy;
  endproperty
  a_ref_start: assert property (p_ref_start)
    else $error("refresh did not start after key");
  property p_ref_walk;
    $rose(refresh_busy) |-> trim_addr == 4'h0 ##1 trim_addr == 4'h1;
  endproperty
  a_ref_walk: assert property (p_ref_walk)
    else $error("refresh walk does not start at word zero");
  property p_ref_step;
    refresh_busy && $past(refresh_busy) |->
      trim_addr == $past(trim_addr) + 4'h1;
  endproperty
  a_ref_step: assert property (p_ref_step)
    else $error("refresh address skipped a word");
  property p_ref_len;
    $rose(refresh_busy) |-> s_walk;
  endproperty
  a_ref_len: assert property (p_ref_len)
    else $error("refresh walk length wrong");
  property p_pin;
    (pin_oe & pin_pulldown) == 3'h0;
  endproperty
  a_pin: assert property (p_pin)
    else $error("pin driven and pulled down at once");
  property p_dead;
    dead_code == 24'h07DEAD;
  endproperty
  a_dead: assert property (p_dead)
    else $error("stopped clock code wrong");
endmodule : dacud_core_asserts
bind dacud_core dacud_core_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr, .pin_oe, .pin_pulldown,
  .trim_addr, .refresh_busy, .adc_start, .wdt_kick, .dead_code);
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import dacud_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic frame_select_n = 1'b1;
  logic load_strobe_pin_n = 1'b1;
  logic wdt_timeout = 1'b0;
  logic corrupt = 1'b0;
  logic bad_ref = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [1:0] dev_addr = 2'h1;
  logic [7:0] analog_faults = 8'h00;
  logic [2:0] pin_in = 3'h0;
  logic [15:0] reg_rdata, latch_readback, trim_data, trim_ref, dac_latch_code;
  logic [2:0] pin_out, pin_oe, pin_pulldown;
  logic [3:0] trim_addr;
  logic refresh_busy, adc_start, wdt_kick, dead_code_enable;
  logic [23:0] dead_code;
  int errors = 0;
  int tests_run = 0;
  int cyc = 0;
  always #2.5 clk_sys = ~clk_sys;
  dacud_core #(.TICK_CYCLES(8)) dut (.clk_sys, .rstn, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .frame_select_n, .load_strobe_pin_n,
    .dev_addr, .wdt_timeout, .latch_readback, .analog_faults, .trim_data,
    .trim_ref, .pin_in, .pin_out, .pin_oe, .pin_pulldown, .dac_latch_code,
    .trim_addr, .refresh_busy, .adc_start, .wdt_kick, .dead_code_enable,
    .dead_code);
  dacud_far_model u_far (.clk_sys, .dac_latch_code, .trim_addr, .corrupt,
    .bad_ref, .latch_readback, .trim_data, .trim_ref);
  task automatic conclude;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  // hang guard, far above the roughly 400 cycles the run needs
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 8000) begin
      errors++;
      conclude();
    end
  end
  task automatic chk(input string n, input logic [15:0] s, e);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic settle;
    repeat (6) @(posedge clk_sys);
    #1;
  endtask : settle
  task automatic frame;
    @(posedge clk_sys);
    frame_select_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    frame_select_n <= 1'b1;
    repeat (4) settle();
  endtask : frame
  task automatic wait_idle;
    repeat (2) @(posedge clk_sys);
    for (int i = 0; i < 40 && refresh_busy !== 1'b0; i++) @(posedge clk_sys);
  endtask : wait_idle
  task automatic t_reset;
    logic [15:0] v;
    rd(A_DIG_FLAGS, v);
    chk("dig flags", v, 16'h0003);
    rd(A_CHECK_CFG, v);
    chk("check cfg", v, 16'h000D);
    rd(A_GEN_CFG1, v);
    chk("gen cfg1", v, 16'h0001);
    rd(A_STATUS, v);
    chk("status", v, 16'h0002);
    chk("pins", {10'h000, pin_oe, pin_pulldown}, 16'h0007);
  endtask : t_reset
  task automatic t_refresh;
    logic [15:0] v;
    wr(A_KEY, KEY_REFRESH);
    wr(A_GAIN, 16'h1234);
    wait_idle();
    rd(A_DIG_FLAGS, v);
    chk("refresh flags", v, 16'h0041);
    rd(A_GAIN, v);
    chk("blocked gain", v, 16'hFFFF);
    wr(A_DIG_FLAGS, 16'h0041);
    rd(A_DIG_FLAGS, v);
    chk("cleared", v, 16'h0000);
    bad_ref <= 1'b1;
    wr(A_DAC_CFG, 16'h0001);
    wait_idle();
    rd(A_DIG_FLAGS, v);
    chk("sum error", v, 16'h0020);
    wr(A_DIG_FLAGS, 16'h00FF);
    rd(A_DIG_FLAGS, v);
    chk("w1c all", v, 16'h0000);
  endtask : t_refresh
  task automatic t_load;
    logic [15:0] old;
    old = dac_latch_code;
    wr(A_INPUT, 16'h1234);
    frame();
    chk("strobe high hold", dac_latch_code, old);
    wr(A_SOFT_LOAD, 16'h0002);
    settle();
    chk("other address", dac_latch_code, old);
    wr(A_SOFT_LOAD, 16'h0001);
    settle();
    chk("soft load", dac_latch_code, 16'h1234);
    load_strobe_pin_n <= 1'b0;
    wr(A_GAIN, 16'h7FFF);
    settle();
    chk("gain alone", dac_latch_code, 16'h1234);
    wr(A_INPUT, 16'h2000);
    frame();
    chk("frame load", dac_latch_code, 16'h1000);
    load_strobe_pin_n <= 1'b1;
    wr(A_GEN_CFG2, 16'h0001);
    wr(A_INPUT, 16'h4000);
    wr(A_SOFT_LOAD, 16'h0002);
    settle();
    chk("global load", dac_latch_code, 16'h2000);
    wr(A_INPUT, 16'h6000);
    load_strobe_pin_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    load_strobe_pin_n <= 1'b1;
    settle();
    chk("pin pulse", dac_latch_code, 16'h3000);
  endtask : t_load
  task automatic t_wdt;
    logic [15:0] v;
    wr(A_FALLBACK, 16'h0F0F);
    wr(A_WDT_CFG, 16'h0400);
    wdt_timeout <= 1'b1;
    @(posedge clk_sys);
    wdt_timeout <= 1'b0;
    settle();
    chk("fallback", dac_latch_code, 16'h0F0F);
    wr(A_INPUT, 16'h2000);
    wr(A_SOFT_LOAD, 16'h0001);
    settle();
    chk("locked", dac_latch_code, 16'h0F0F);
    rd(A_STATUS, v);
    chk("wdt status", v, 16'h0006);
    wr(A_DIG_FLAGS, 16'h0004);
    wr(A_INPUT, 16'h2000);
    wr(A_SOFT_LOAD, 16'h0001);
    settle();
    chk("unlocked", dac_latch_code, 16'h1000);
    wr(A_DAC_CFG, 16'h0F11);
    wr(A_INPUT, 16'h2040);
    wr(A_SOFT_LOAD, 16'h0001);
    rd(A_DIG_FLAGS, v);
    chk("slew busy", v, 16'h0080);
    repeat (5) settle();
    chk("slewed", dac_latch_code, 16'h1020);
    rd(A_DIG_FLAGS, v);
    chk("slew done", v, 16'h0000);
  endtask : t_wdt
  task automatic t_diag;
    logic [15:0] v;
    wr(A_CHECK_CFG, 16'h000F);
    corrupt <= 1'b1;
    settle();
    wr(A_DIG_FLAGS, 16'h0008);
    rd(A_DIG_FLAGS, v);
    chk("latch persists", v, 16'h0008);
    corrupt <= 1'b0;
    analog_faults <= 8'h01;
    @(posedge clk_sys);
    analog_faults <= 8'h02;
    settle();
    wr(A_DIG_FLAGS, 16'h0008);
    rd(A_DIG_FLAGS, v);
    chk("latch cleared", v, 16'h0000);
    wr(A_ANA_FLAGS, 16'h0003);
    rd(A_ANA_FLAGS, v);
    chk("analog live", v, 16'h0002);
    rd(A_STATUS, v);
    chk("analog or", v, 16'h0001);
  endtask : t_diag
  task automatic t_misc;
    logic [15:0] a, b;
    rd(A_TICKS, a);
    repeat (78) @(posedge clk_sys);
    rd(A_TICKS, b);
    chk("ticks", b - a, 16'h000A);
    wr(A_PIN_FUNC, 16'h0009);
    wr(A_PIN_DATA, 16'h0001);
    pin_in <= 3'h2;
    settle();
    chk("pin mode", {9'h000, pin_out[0], pin_oe, pin_pulldown},
        16'h004C);
    rd(A_PIN_DATA, a);
    chk("pin in", a, 16'h0003);
    wr(A_KEY, KEY_ADC);
    wr(A_KEY, KEY_KICK);
    wr(A_GEN_CFG1, 16'h0000);
    wr(A_KEY, KEY_RST1);
    chk("dead off", {15'h0000, dead_code_enable}, 16'h0000);
    wr(A_KEY, KEY_RST2);
    settle();
    rd(A_GAIN, a);
    chk("soft reset gain", a, 16'hFFFF);
    rd(A_DIG_FLAGS, a);
    chk("reset seen", a, 16'h0003);
    chk("dead on", {15'h0000, dead_code_enable}, 16'h0001);
  endtask : t_misc
  initial begin
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset();
    t_refresh();
    t_load();
    t_wdt();
    t_diag();
    t_misc();
    conclude();
  end
endmodule : tb
`default_nettype wire
